// *** hdl/pcmh_pkg.sv ***
/*
 * Shared constants for the phase-change memory host controller: the command
 * codes, the status word bit positions, the local register map and the bus
 * timing figures.
 * Assumes a single 125 MHz clock domain and an asynchronous parallel memory.
 */
package pcmh_pkg;
  // ==========================================================================
  // memory command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK_CFM = 8'h01;
  localparam logic [7:0] CMD_UNLOCK_CFM = 8'hD0;
  localparam logic [7:0] CMD_LOCKDOWN_CFM = 8'h2F;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_OTP_SETUP = 8'hC0;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam int unsigned LOCK_STAT_OFS = 2;

  // ==========================================================================
  // operation status word bit positions
  localparam int unsigned LOCKED_ABORT_BIT = 1;
  localparam int unsigned PROG_VOLTAGE_ERROR_BIT = 3;
  localparam int unsigned PROGRAM_FAIL_BIT = 4;
  localparam int unsigned ENGINE_READY_BIT = 7;

  // ==========================================================================
  // orders software may give (ctrl register, op field)
  localparam logic [3:0] OP_LOCK = 4'h0;
  localparam logic [3:0] OP_UNLOCK = 4'h1;
  localparam logic [3:0] OP_LOCKDOWN = 4'h2;
  localparam logic [3:0] OP_READ_LOCK = 4'h3;
  localparam logic [3:0] OP_OTP_PROG = 4'h4;
  localparam logic [3:0] OP_READ_STATUS = 4'h5;
  localparam logic [3:0] OP_CLEAR_STATUS = 4'h6;
  localparam logic [3:0] OP_READ_ARRAY = 4'h7;
  localparam logic [3:0] OP_SUSPEND = 4'h8;

  // ==========================================================================
  // local register map (byte offsets on the apb bus)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_REFUSED = 1;
  localparam int unsigned STAT_ERR = 2;
  localparam int unsigned STAT_WORD_LSB = 8;

  // ==========================================================================
  // step kinds of the bus sequencer
  localparam logic [1:0] STEP_DONE = 2'h0;
  localparam logic [1:0] STEP_WRITE = 2'h1;
  localparam logic [1:0] STEP_READ = 2'h2;
  localparam logic [1:0] STEP_POLL = 2'h3;

  // ==========================================================================
  // bus timing
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned WE_PULSE_NS = 80;
  localparam int unsigned RD_ACCESS_NS = 160;
  localparam int unsigned RECOVER_NS = 40;
  localparam int unsigned WE_PULSE_CYC = (WE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RD_ACCESS_CYC = (RD_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RECOVER_CYC = (RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_SETUP = 4'b0010,
    PH_ACT = 4'b0100,
    PH_RECOV = 4'b1000
  } pcmh_phase_t;
endpackage

// *** hdl/pcmh_host.sv ***
/*
 * Host controller for a parallel phase-change memory: takes orders over apb,
 * runs the lock, lock-status, protection-area program and status command
 * sequences on the memory's strobe pins and reports results.
 * Assumes memory inputs are synchronous to sys_clk and one order at a time.
 */
// Function
// - lock change: setup 60h then 01h, D0h or 2Fh at block address
// - lock check: write 90h, then read block base plus two
// - after program or lock the host writes FFh to return to array reads
// - protection program: write C0h, then data at target location
// - host clears status after an error before retrying a lock change or program
// - error bits accumulate; host may check once after a series
// - status refreshes only when chip or output enable toggles between reads
`timescale 1ns/10ps
`default_nettype none
module pcmh_host
  import pcmh_pkg::*;
#(
  parameter int unsigned ADDR_W = 23,
  parameter int unsigned DATA_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [ADDR_W-1:0] pcm_addr,
  output logic pcm_ce_n,
  output logic pcm_oe_n,
  output logic pcm_we_n,
  output logic [DATA_W-1:0] pcm_dq_o,
  output logic pcm_dq_oe,
  input wire logic [DATA_W-1:0] pcm_dq_i
);
  // ==========================================================================
  // apb slave
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [3:0] op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rdata_q;
  logic [7:0] status_q;
  logic busy_q;
  logic refused_q;
  logic err_q;

  // one wait state: access phase answered on its second edge
  wire apb_access = psel && penable && !pready_q;
  wire apb_done = psel && penable && pready_q;
  wire hit_ctrl = (paddr == REG_CTRL);
  wire hit_addr = (paddr == REG_ADDR);
  wire hit_wdata = (paddr == REG_WDATA);
  wire hit_stat = (paddr == REG_STAT);
  wire hit_rdata = (paddr == REG_RDATA);
  wire hit_any = hit_ctrl || hit_addr || hit_wdata || hit_stat || hit_rdata;
  wire wr_ctrl = apb_done && pwrite && hit_ctrl && !pslverr_q;
  wire wr_addr = apb_done && pwrite && hit_addr && !busy_q;
  wire wr_wdata = apb_done && pwrite && hit_wdata && !busy_q;
  wire [3:0] new_op = pwdata[3:0];

  // orders that change the array are held back while an error is pending
  wire new_is_change = (new_op == OP_LOCK) || (new_op == OP_UNLOCK) ||
                       (new_op == OP_LOCKDOWN) || (new_op == OP_OTP_PROG);
  wire new_legal = new_op <= OP_SUSPEND;
  wire start = wr_ctrl && !busy_q && new_legal && !(new_is_change && err_q);
  wire refuse = wr_ctrl && !start;

  wire [31:0] stat_word = {16'h0000, status_q, 5'h00, err_q, refused_q, busy_q};
  wire [31:0] rd_mux = hit_ctrl ? {28'h0000000, op_q} :
                       hit_addr ? {{(32 - ADDR_W){1'b0}}, addr_q} :
                       hit_wdata ? {{(32 - DATA_W){1'b0}}, wdata_q} :
                       hit_stat ? stat_word :
                       hit_rdata ? {{(32 - DATA_W){1'b0}}, rdata_q} : 32'h00000000;

  // answer registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= apb_access;
      pslverr_q <= apb_access && !hit_any;
      prdata_q <= (apb_access && !pwrite) ? rd_mux : prdata_q;
    end
  end

  // software-written order fields; address and data frozen while busy
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      op_q <= OP_READ_ARRAY;
      addr_q <= '0;
      wdata_q <= '0;
    end else begin
      if (start) op_q <= new_op;
      if (wr_addr) addr_q <= pwdata[ADDR_W-1:0];
      if (wr_wdata) wdata_q <= pwdata[DATA_W-1:0];
    end
  end

  // ==========================================================================
  // step table: {kind, plus two, use wdata, code}
  function automatic logic [11:0] step_f(input logic [3:0] op, input logic [1:0] idx);
    logic [7:0] cfm;
    cfm = (op == OP_UNLOCK) ? CMD_UNLOCK_CFM :
          (op == OP_LOCKDOWN) ? CMD_LOCKDOWN_CFM : CMD_LOCK_CFM;
    step_f = {STEP_DONE, 2'b00, 8'h00};
    case (op)
      OP_LOCK, OP_UNLOCK, OP_LOCKDOWN: begin
        case (idx)
          2'd0: step_f = {STEP_WRITE, 2'b00, CMD_LOCK_SETUP};
          2'd1: step_f = {STEP_WRITE, 2'b00, cfm};
          2'd2: step_f = {STEP_WRITE, 2'b00, CMD_READ_ARRAY};
          default: step_f = {STEP_DONE, 2'b00, 8'h00};
        endcase
      end
      OP_READ_LOCK: begin
        case (idx)
          2'd0: step_f = {STEP_WRITE, 2'b10, CMD_READ_ID};
          2'd1: step_f = {STEP_READ, 2'b10, 8'h00};
          2'd2: step_f = {STEP_WRITE, 2'b00, CMD_READ_ARRAY};
          default: step_f = {STEP_DONE, 2'b00, 8'h00};
        endcase
      end
      OP_OTP_PROG: begin
        case (idx)
          2'd0: step_f = {STEP_WRITE, 2'b00, CMD_OTP_SETUP};
          2'd1: step_f = {STEP_WRITE, 2'b01, 8'h00};
          2'd2: step_f = {STEP_POLL, 2'b00, 8'h00};
          default: step_f = {STEP_WRITE, 2'b00, CMD_READ_ARRAY};
        endcase
      end
      OP_READ_STATUS: begin
        case (idx)
          2'd0: step_f = {STEP_WRITE, 2'b00, CMD_READ_STATUS};
          2'd1: step_f = {STEP_POLL, 2'b00, 8'h00};
          default: step_f = {STEP_DONE, 2'b00, 8'h00};
        endcase
      end
      OP_CLEAR_STATUS: begin
        case (idx)
          2'd0: step_f = {STEP_WRITE, 2'b00, CMD_CLEAR_STATUS};
          default: step_f = {STEP_DONE, 2'b00, 8'h00};
        endcase
      end
      OP_READ_ARRAY: begin
        case (idx)
          2'd0: step_f = {STEP_WRITE, 2'b00, CMD_READ_ARRAY};
          2'd1: step_f = {STEP_READ, 2'b00, 8'h00};
          default: step_f = {STEP_DONE, 2'b00, 8'h00};
        endcase
      end
      OP_SUSPEND: begin
        case (idx)
          2'd0: step_f = {STEP_WRITE, 2'b00, CMD_SUSPEND};
          default: step_f = {STEP_DONE, 2'b00, 8'h00};
        endcase
      end
      default: step_f = {STEP_DONE, 2'b00, 8'h00};
    endcase
  endfunction

  // ==========================================================================
  // memory bus sequencer
  pcmh_phase_t ph_q, ph_d;
  logic [1:0] idx_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  wire [11:0] step = step_f(op_q, idx_q);
  wire [1:0] kind = step[11:10];
  wire is_write = (kind == STEP_WRITE);
  wire is_poll = (kind == STEP_POLL);
  wire [ADDR_W-1:0] step_addr = addr_q + (step[9] ? ADDR_W'(LOCK_STAT_OFS) : ADDR_W'(0));
  wire [DATA_W-1:0] step_data = step[8] ? wdata_q : {{(DATA_W - 8){1'b0}}, step[7:0]};
  wire [7:0] act_len = is_write ? 8'(WE_PULSE_CYC) : 8'(RD_ACCESS_CYC);
  wire cnt_end = (cnt_q == 8'h01);
  wire sample = (ph_q == PH_ACT) && cnt_end && !is_write;
  wire engine_ready = pcm_dq_i[ENGINE_READY_BIT];
  // keep polling the same step until the engine reports ready
  wire step_repeat = is_poll && !status_q[ENGINE_READY_BIT];
  // the last table row ends the order too, so the index never wraps back to row zero
  wire last_row = (&idx_q) || (step_f(op_q, idx_q + 2'd1) == {STEP_DONE, 2'b00, 8'h00});
  wire seq_end = (ph_q == PH_RECOV) && cnt_end && !step_repeat && last_row;

  // error bits gathered from the status word accumulate until cleared
  wire [7:0] err_mask = 8'((1 << LOCKED_ABORT_BIT) | (1 << PROG_VOLTAGE_ERROR_BIT) |
                           (1 << PROGRAM_FAIL_BIT));
  wire err_seen = sample && is_poll && engine_ready && |(pcm_dq_i[7:0] & err_mask);
  wire clear_done = seq_end && (op_q == OP_CLEAR_STATUS);

  // phase next state
  always_comb begin
    ph_d = ph_q;
    cnt_d = cnt_q;
    case (ph_q)
      PH_IDLE: begin
        if (start) ph_d = PH_SETUP;
      end
      PH_SETUP: begin
        if (kind == STEP_DONE) ph_d = PH_IDLE;
        else begin
          ph_d = PH_ACT;
          cnt_d = act_len;
        end
      end
      PH_ACT: begin
        if (cnt_end) begin
          ph_d = PH_RECOV;
          cnt_d = 8'(RECOVER_CYC);
        end else cnt_d = cnt_q - 8'h01;
      end
      PH_RECOV: begin
        if (cnt_end) ph_d = seq_end ? PH_IDLE : PH_SETUP;
        else cnt_d = cnt_q - 8'h01;
      end
      default: ph_d = PH_IDLE;
    endcase
  end

  // sequencer state; a poll reuses its step after a full strobe release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph_q <= PH_IDLE;
      cnt_q <= 8'h00;
      idx_q <= 2'd0;
    end else begin
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      if (start) idx_q <= 2'd0;
      else if (ph_q == PH_RECOV && cnt_end && !step_repeat) idx_q <= idx_q + 2'd1;
    end
  end

  // pins: strobes all high in recovery so every read is a fresh ce/oe edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pcm_addr <= '0;
      pcm_ce_n <= 1'b1;
      pcm_oe_n <= 1'b1;
      pcm_we_n <= 1'b1;
      pcm_dq_o <= '0;
      pcm_dq_oe <= 1'b0;
    end else begin
      pcm_addr <= (ph_d == PH_ACT) ? step_addr : pcm_addr;
      pcm_dq_o <= (ph_d == PH_ACT) ? step_data : pcm_dq_o;
      pcm_ce_n <= (ph_d != PH_ACT);
      pcm_oe_n <= !((ph_d == PH_ACT) && !is_write);
      pcm_we_n <= !((ph_d == PH_ACT) && is_write);
      pcm_dq_oe <= (ph_d == PH_ACT) && is_write;
    end
  end

  // results and flags; the error set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      refused_q <= 1'b0;
      err_q <= 1'b0;
      status_q <= 8'h00;
      rdata_q <= '0;
    end else begin
      busy_q <= (ph_d != PH_IDLE);
      if (start) refused_q <= 1'b0;
      else if (refuse) refused_q <= 1'b1;
      if (err_seen) err_q <= 1'b1;
      else if (clear_done) err_q <= 1'b0;
      if (sample && is_poll) status_q <= pcm_dq_i[7:0];
      if (sample) rdata_q <= pcm_dq_i;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule // pcmh_host
`default_nettype wire

// *** bench/pcmh_host_properties.sv ***
/*
 * Port-level checker for pcmh_host: apb answer timing and memory strobe shapes.
 * Assumes it is bound into pcmh_host and sees only that module's ports.
 */
`timescale 1ns/10ps
`default_nettype none
module pcmh_host_properties
  import pcmh_pkg::*;
#(
  parameter int unsigned ADDR_W = 23,
  parameter int unsigned DATA_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ADDR_W-1:0] pcm_addr,
  input wire logic pcm_ce_n,
  input wire logic pcm_oe_n,
  input wire logic pcm_we_n,
  input wire logic [DATA_W-1:0] pcm_dq_o,
  input wire logic pcm_dq_oe,
  input wire logic [DATA_W-1:0] pcm_dq_i
);
  // ==========================================================================
  // step shapes
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ten low cycles, counted from the falling edge
  sequence we_run;
    (!pcm_we_n)[*8] ##1 !pcm_we_n ##1 pcm_we_n;
  endsequence
  // twenty low cycles of output enable
  sequence oe_run;
    (!pcm_oe_n)[*8] ##1 (!pcm_oe_n)[*8] ##1 (!pcm_oe_n)[*3] ##1 pcm_oe_n;
  endsequence
  sequence idle_gap;
    (pcm_ce_n && pcm_we_n && pcm_oe_n)[*5];
  endsequence
  // ==========================================================================
  // assertions
  apb_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  slverr_map_a: assert property (pready |-> pslverr == (paddr > REG_RDATA || paddr[1:0] != 2'h0))
    else $error("pslverr does not match address decode");
  we_pulse_a: assert property ($fell(pcm_we_n) |=> we_run)
    else $error("write strobe length wrong");
  oe_pulse_a: assert property ($fell(pcm_oe_n) |=> oe_run)
    else $error("read strobe length wrong");
  we_qual_a: assert property (!pcm_we_n |-> pcm_oe_n && !pcm_ce_n && pcm_dq_oe)
    else $error("write strobe without chip enable or drive");
  oe_qual_a: assert property (!pcm_oe_n |-> !pcm_ce_n && !pcm_dq_oe)
    else $error("data driven during a read");
  ce_toggle_a: assert property ($rose(pcm_ce_n) |-> idle_gap)
    else $error("recovery gap too short");
  write_held_a: assert property (!pcm_we_n && $past(!pcm_we_n) |-> $stable(pcm_dq_o) && $stable(pcm_addr))
    else $error("address or data moved under write strobe");
endmodule // pcmh_host_properties
bind pcmh_host pcmh_host_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pcm_addr(pcm_addr), .pcm_ce_n(pcm_ce_n), .pcm_oe_n(pcm_oe_n), .pcm_we_n(pcm_we_n),
  .pcm_dq_o(pcm_dq_o), .pcm_dq_oe(pcm_dq_oe), .pcm_dq_i(pcm_dq_i));
`default_nettype wire

// *** bench/pcmh_mem_model.sv ***
/*
 * Behavioural memory: command decoder, lock bits, protection area, status word.
 * Assumes strobes are synchronous to sys_clk; commands act when the write strobe rises.
 */
`timescale 1ns/10ps
`default_nettype none
module pcmh_mem_model
  import pcmh_pkg::*;
#(
  parameter int unsigned BUSY_CYC = 30,
  parameter logic [22:0] PR_BASE = 23'h000080
) (
  input wire logic sys_clk,
  input wire logic [22:0] pcm_addr,
  input wire logic pcm_ce_n,
  input wire logic pcm_oe_n,
  input wire logic pcm_we_n,
  input wire logic [15:0] pcm_dq_o,
  input wire logic vpp_bad,
  input wire logic prog_fail,
  output logic [15:0] pcm_dq_i
);
  logic [1:0] lk [8];
  logic [15:0] pr [16];
  logic [6:0] sr = 7'h00;
  logic [1:0] mode = 2'h0;
  logic [1:0] setup = 2'h0;
  int busy = 0;
  logic [22:0] a = 23'h0;
  logic [15:0] d = 16'h0;
  logic [15:0] rd = 16'h0;
  logic we_d = 1'b1;
  logic oe_d = 1'b1;
  wire logic in_pr = a >= PR_BASE && a < PR_BASE + 23'h10;
  initial begin
    foreach (lk[i]) lk[i] = 2'h0;
    foreach (pr[i]) pr[i] = 16'hFFFF;
  end
  // released bus shows the inverse of the last value, not a held copy
  assign pcm_dq_i = (!pcm_ce_n && !pcm_oe_n) ? rd : ~rd;
  // ==========================================================================
  // strobe tracking and command decode
  always @(posedge sys_clk) begin
    we_d <= pcm_we_n;
    oe_d <= pcm_oe_n;
    if (busy > 0) busy = busy - 1;
    if (!pcm_we_n) begin
      a <= pcm_addr;
      d <= pcm_dq_o;
    end
    // output word only refreshes on an output-enable fall
    if (oe_d && !pcm_oe_n) begin
      case (mode)
        2'h1: rd = {8'h00, busy == 0, sr};
        2'h2: rd = (pcm_addr[15:0] == 16'h2) ? {14'h0, lk[pcm_addr[18:16]]} : 16'h0;
        default: rd = pr[pcm_addr[3:0]];
      endcase
    end
    if (!we_d && pcm_we_n) begin
      if (setup == 2'h1) begin
        if (d[7:0] == CMD_UNLOCK_CFM) lk[a[18:16]] = lk[a[18:16]][1] ? 2'h3 : 2'h0;
        else if (d[7:0] == CMD_LOCK_CFM) lk[a[18:16]][0] = 1'b1;
        else if (d[7:0] == CMD_LOCKDOWN_CFM) lk[a[18:16]] = 2'h3;
        else sr[5:4] = 2'h3;
        setup = 2'h0;
      end else if (setup == 2'h2) begin
        if (!in_pr) sr[PROGRAM_FAIL_BIT] = 1'b1;
        else if (lk[a[18:16]][0]) sr[LOCKED_ABORT_BIT] = 1'b1;
        else if (vpp_bad) sr[PROG_VOLTAGE_ERROR_BIT] = 1'b1;
        else if (prog_fail) sr[PROGRAM_FAIL_BIT] = 1'b1;
        else pr[a[3:0]] = d;
        busy = BUSY_CYC;
        setup = 2'h0;
      end else if (busy > 0) begin
        if (d[7:0] == CMD_READ_STATUS) mode = 2'h1;
      end else begin
        case (d[7:0])
          CMD_READ_ARRAY: mode = 2'h0;
          CMD_READ_ID: mode = 2'h2;
          CMD_READ_STATUS: mode = 2'h1;
          CMD_CLEAR_STATUS: sr = 7'h00;
          CMD_LOCK_SETUP: setup = 2'h1;
          CMD_OTP_SETUP: setup = 2'h2;
          default: ;
        endcase
        if (setup != 2'h0) mode = 2'h1;
      end
    end
  end
endmodule // pcmh_mem_model
`default_nettype wire

// *** bench/testbench.sv ***
/*
 * Testbench for pcmh_host: apb tasks drive orders against the memory model.
 * Assumes the register map and op codes of pcmh_pkg.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pcmh_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic vpp_bad = 1'b0;
  logic prog_fail = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, serr, ce_n, oe_n, we_n, dq_oe;
  logic [22:0] pcm_addr;
  logic [15:0] dq_o, dq_i;
  logic [1:0] lkx [3] = '{2'h1, 2'h0, 2'h3};
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  pcmh_host dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pcm_addr(pcm_addr), .pcm_ce_n(ce_n), .pcm_oe_n(oe_n),
    .pcm_we_n(we_n), .pcm_dq_o(dq_o), .pcm_dq_oe(dq_oe), .pcm_dq_i(dq_i));
  pcmh_mem_model mem (.sys_clk(sys_clk), .pcm_addr(pcm_addr), .pcm_ce_n(ce_n),
    .pcm_oe_n(oe_n), .pcm_we_n(we_n), .pcm_dq_o(dq_o), .vpp_bad(vpp_bad),
    .prog_fail(prog_fail), .pcm_dq_i(dq_i));
  initial forever #4 sys_clk = ~sys_clk;
  // ==========================================================================
  // shared tasks
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; an idle cycle follows so no signal is set twice at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      t++;
    end while (pready !== 1'b1 && t < 100);
    if (t >= 100) n_fail++;
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // start an order, then poll until busy clears; rd ends holding the status
  task automatic run(input logic [3:0] op);
    int t;
    t = 0;
    apb(1'b1, REG_CTRL, {28'h0, op});
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      t++;
    end while (rd[STAT_BUSY] !== 1'b0 && t < 200);
    if (t >= 200) n_fail++;
  endtask
  task automatic otp(input logic [31:0] a, input logic [31:0] d, input logic [7:0] sw);
    apb(1'b1, REG_ADDR, a);
    apb(1'b1, REG_WDATA, d);
    run(OP_OTP_PROG);
    check(rd[15:8], sw);
    check(rd[STAT_ERR], sw[4] | sw[3] | sw[1]);
  endtask
  // ==========================================================================
  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  // ==========================================================================
  // scenarios
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    apb(1'b0, 8'h20, 32'h0);
    check(serr, 1'b1);
    check(rd, 32'h0);
    // lock, unlock, lock down, each confirmed by a lock-state read
    apb(1'b1, REG_ADDR, 32'h10000);
    for (int i = 0; i < 3; i++) begin
      run(4'(i));
      run(OP_READ_LOCK);
      apb(1'b0, REG_RDATA, 32'h0);
      check(rd[1:0], lkx[i]);
    end
    otp(32'h83, 32'h5A5A, 8'h80);
    run(OP_READ_ARRAY);
    apb(1'b0, REG_RDATA, 32'h0);
    check(rd[15:0], 16'h5A5A);
    // out of range program, then a refused retry while the error stands
    otp(32'h200, 32'h1111, 8'h90);
    run(OP_OTP_PROG);
    check(rd[STAT_REFUSED], 1'b1);
    run(OP_READ_STATUS);
    check(rd[15:8], 8'h90);
    run(OP_READ_ARRAY);
    apb(1'b0, REG_RDATA, 32'h0);
    check(rd[15:0], 16'hFFFF);
    run(OP_CLEAR_STATUS);
    check(rd[STAT_ERR], 1'b0);
    // supply fault then program failure, each cleared before the next try
    for (int k = 0; k < 2; k++) begin
      vpp_bad <= (k == 0);
      prog_fail <= (k == 1);
      otp(32'h84, 32'h2222, (k == 0) ? 8'h88 : 8'h90);
      run(OP_CLEAR_STATUS);
    end
    vpp_bad <= 1'b0;
    prog_fail <= 1'b0;
    apb(1'b1, REG_ADDR, 32'h0);
    run(OP_LOCK);
    otp(32'h85, 32'h3333, 8'h82);
    run(OP_CLEAR_STATUS);
    run(OP_READ_STATUS);
    check(rd[15:8], 8'h80);
    run(OP_SUSPEND);
    check(rd[STAT_ERR], 1'b0);
    summarize();
  end
endmodule // testbench
`default_nettype wire
